// ===== threshold_cam_output_switch.sv
`timescale 1ns/100ps
`default_nettype none
//
// Summary of operation
// RQ1 - reference select: 0 counter, 2 frequency
// RQ2 - eight 32-bit thresholds, each with level
// RQ3 - frequency mode: two thresholds, high then low
// RQ4 - per-threshold duration up to 24000 us
// RQ5 - count 1..8 counter, 1 or 2 frequency
// RQ6 - two block flags choose active directions
// RQ7 - automatic mode ignores manual output level
// RQ8 - enabling at standstill keeps last state
// RQ9 - count n activates thresholds 1 to n
// RQ10 - controller should program count of at least one
// RQ11 - low on threshold above high: window cam
// RQ12 - switch-on point depends on travel direction
// RQ13 - swapped thresholds invert the cam window
// RQ14 - time cams hold level for duration
// RQ15 - two independent tracks, cams updatable anytime
// RQ16 - new threshold restarts running duration timer
// RQ17 - preset load never switches the output
// RQ18 - blocked direction forces output low
// RQ19 - compare on each counter update, same cycle
module threshold_cam_output_switch (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [cam_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [cam_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cam_pkg::enc_in_t enc,
   input wire cam_pkg::freq_in_t freq,
   output logic [cam_pkg::NUM_TRACKS-1:0] dig_out_q
);
   import cam_pkg::*;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   logic wr_en;
   reg_wr_t wr;
   logic wr_err;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;

   logic [CTRL_W-1:0] ctrl_q [NUM_TRACKS];
   logic [COUNT_W-1:0] count_q [NUM_TRACKS];
   logic [NUM_THR-1:0] levels_q [NUM_TRACKS];
   logic [NUM_THR-1:0][31:0] thr_q [NUM_TRACKS];
   logic [NUM_THR-1:0][DUR_W-1:0] dur_q [NUM_TRACKS];

   logic [NUM_TRACKS-1:0] auto_q;
   logic [NUM_TRACKS-1:0] fwd_q;
   logic [NUM_TRACKS-1:0] run;
   logic [NUM_TRACKS-1:0] blocked;

   function automatic logic is_mapped(input logic [6:0] off);
      logic ok;
      ok = 1'b0;
      if (off == OFF_CTRL || off == OFF_COUNT || off == OFF_LEVELS ||
          off == OFF_STATUS) begin
         ok = 1'b1;
      end
      if (off[6:5] == BANK_THR || off[6:5] == BANK_DUR) begin
         ok = 1'b1;
      end
      return ok;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = val[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // lowest-numbered matching threshold wins; only 1..n take part
   function automatic logic [3:0] first_hit(
      input logic [31:0] v,
      input logic [NUM_THR-1:0][31:0] t,
      input logic [COUNT_W-1:0] n);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NUM_THR - 1; i >= 0; i--) begin
         if (COUNT_W'(i) < n && v == t[i]) begin // RQ9
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   axil_port u_port (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr(wr),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   assign wr_err = !is_mapped(wr.addr[6:0]);
   assign rd_err = !is_mapped(rd_addr[6:0]);

   // cam tables may be rewritten at any time while the track runs
   always_ff @(posedge core_clk) begin // RQ15
      if (sys_rst) begin
         for (int t = 0; t < NUM_TRACKS; t++) begin
            ctrl_q[t] <= CTRL_RST;
            count_q[t] <= COUNT_RST;
            levels_q[t] <= LEVELS_RST;
            thr_q[t] <= '0;
            dur_q[t] <= '0;
         end
      end else if (wr_en && !wr_err) begin
         logic t;
         logic [6:0] off;
         logic [2:0] k;
         logic [31:0] m;
         t = wr.addr[TRACK_SEL_BIT];
         off = wr.addr[6:0];
         k = off[4:2];
         if (off == OFF_CTRL) begin
            m = merge({26'h0, ctrl_q[t]}, wr.data, wr.strb);
            ctrl_q[t] <= m[CTRL_W-1:0];
         end
         if (off == OFF_COUNT) begin
            m = merge({28'h0, count_q[t]}, wr.data, wr.strb);
            count_q[t] <= m[COUNT_W-1:0];
         end
         if (off == OFF_LEVELS) begin // RQ2
            m = merge({24'h0, levels_q[t]}, wr.data, wr.strb);
            levels_q[t] <= m[NUM_THR-1:0];
         end
         if (off[6:5] == BANK_THR) begin // RQ2
            thr_q[t][k] <= merge(thr_q[t][k], wr.data, wr.strb);
         end
         if (off[6:5] == BANK_DUR) begin
            // durations beyond the ceiling are clipped, not wrapped
            m = merge({17'h0, dur_q[t][k]}, wr.data, wr.strb);
            dur_q[t][k] <= (m > {17'h0, DUR_MAX_US}) ? DUR_MAX_US
                                                      : m[DUR_W-1:0]; // RQ4
         end
      end
   end

   always_comb begin
      logic t;
      logic [6:0] off;
      t = rd_addr[TRACK_SEL_BIT];
      off = rd_addr[6:0];
      rd_data = 32'h0000_0000;
      if (off == OFF_CTRL) begin
         rd_data = {26'h0, ctrl_q[t]};
      end else if (off == OFF_COUNT) begin
         rd_data = {28'h0, count_q[t]};
      end else if (off == OFF_LEVELS) begin
         rd_data = {24'h0, levels_q[t]};
      end else if (off == OFF_STATUS) begin
         rd_data[STAT_PIN_BIT] = dig_out_q[t];
         rd_data[STAT_AUTO_BIT] = auto_q[t];
         rd_data[STAT_RUN_BIT] = run[t];
         rd_data[STAT_FWD_BIT] = fwd_q[t];
         rd_data[STAT_BLK_BIT] = blocked[t];
      end else if (off[6:5] == BANK_THR) begin
         rd_data = thr_q[t][off[4:2]];
      end else if (off[6:5] == BANK_DUR) begin
         rd_data = {17'h0, dur_q[t][off[4:2]]};
      end
   end

   for (genvar g = 0; g < NUM_TRACKS; g++) begin : g_track
      logic en;
      logic manual;
      logic [1:0] ref_sel;
      logic is_cnt;
      logic is_freq;
      logic fwd_now;
      logic [COUNT_W-1:0] n_cnt;
      logic [COUNT_W-1:0] n_eff;
      logic [3:0] hit_w;
      logic hit;
      logic [2:0] idx;
      logic hit_lvl;
      logic [DUR_W-1:0] hit_dur;
      logic take;
      logic t_start;
      logic t_stop;
      logic expired;
      logic auto_d;

      assign en = ctrl_q[g][CTRL_EN_BIT];
      assign manual = ctrl_q[g][CTRL_MANUAL_BIT];
      assign ref_sel = ctrl_q[g][CTRL_REF_LSB +: 2]; // RQ1
      assign is_cnt = (ref_sel == REF_COUNTER); // RQ1
      assign is_freq = (ref_sel == REF_FREQ); // RQ1
      assign n_cnt = (count_q[g] > COUNT_MAX) ? COUNT_MAX : count_q[g];
      // frequency mode has only two thresholds
      assign n_eff = (is_freq && n_cnt > COUNT_FREQ_MAX) ? COUNT_FREQ_MAX
                                                         : n_cnt; // RQ5
      // at standstill the last seen direction decides
      assign fwd_now = enc.step ? enc.up : fwd_q[g]; // RQ18
      assign blocked[g] = is_cnt && (fwd_now ? ctrl_q[g][CTRL_BLK_FWD_BIT]
                                   : ctrl_q[g][CTRL_BLK_BWD_BIT]); // RQ6
      assign hit_w = first_hit(enc.value, thr_q[g], n_eff); // RQ19
      assign hit = hit_w[3];
      assign idx = hit_w[2:0];
      // backward travel swaps the on and off points of a position cam
      assign hit_lvl = levels_q[g][idx]
                       ^ (!enc.up && hit_dur == 15'h0000); // RQ12
      assign hit_dur = dur_q[g][idx];
      // only a counting pulse takes a hit; a preset load is ignored
      assign take = en && is_cnt && !blocked[g] && enc.step && hit; // RQ17
      assign t_start = take && (hit_dur != 15'h0000); // RQ16
      assign t_stop = !en || !is_cnt || blocked[g] || take; // RQ4

      dur_timer u_timer (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .start(t_start),
         .stop(t_stop),
         .dur_us(hit_dur),
         .running(run[g]),
         .expired(expired)
      );

      // ordered thresholds give the window cam; edges follow travel
      always_comb begin // RQ11 RQ12 RQ13
         auto_d = auto_q[g];
         if (en && is_cnt) begin
            if (blocked[g]) begin
               auto_d = 1'b0; // RQ18
            end else if (take) begin
               auto_d = hit_lvl; // RQ2 RQ14
            end else if (expired) begin
               auto_d = !auto_q[g]; // RQ14
            end
         end else if (en && is_freq && freq.upd && n_eff != 4'h0) begin
            if (freq.value >= thr_q[g][0]) begin
               auto_d = 1'b1; // RQ3
            end else if (n_eff == 4'h1 || freq.value <= thr_q[g][1]) begin
               auto_d = 1'b0; // RQ3 RQ5
            end
         end
      end

      // auto level is kept while disabled, so re-enabling resumes it
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            auto_q[g] <= 1'b0; // RQ8
         end else begin
            auto_q[g] <= auto_d;
         end
      end

      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            fwd_q[g] <= 1'b1;
         end else if (enc.step) begin
            fwd_q[g] <= enc.up;
         end
      end

      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            dig_out_q[g] <= 1'b0;
         end else begin
            dig_out_q[g] <= en ? auto_d : manual; // RQ7 RQ8
         end
      end

      sequence s_cam_hit;
         take;
      endsequence

      sequence s_level_applied;
         ##1 (auto_q[g] == $past(hit_lvl));
      endsequence

      AST_MANUAL_IGNORED: assert property ( // RQ7
         $past(en) && en |-> dig_out_q[g] == auto_q[g])
         else $error("output follows manual level while automatic");

      AST_LEVEL_ON_HIT: assert property ( // RQ2
         s_cam_hit |-> s_level_applied)
         else $error("hit threshold level not applied");

      AST_PRESET_NO_SWITCH: assert property ( // RQ17
         en && is_cnt && !enc.step && !expired && !blocked[g]
         |=> $stable(auto_q[g]))
         else $error("output switched without a counting pulse");

      AST_BLOCKED_LOW: assert property ( // RQ18
         en && blocked[g] |=> !auto_q[g] ##0 !dig_out_q[g])
         else $error("blocked direction did not force output low");

      AST_TIMER_RESTART: assert property ( // RQ16
         s_cam_hit ##0 (hit_dur != 15'h0000) |=> run[g])
         else $error("duration timer not restarted on new threshold");

      AST_ZERO_DUR_HOLD: assert property ( // RQ4
         s_cam_hit ##0 (hit_dur == 15'h0000) |=> !run[g] ##1 !expired)
         else $error("zero duration started a timer");

      AST_HIT_IN_RANGE: assert property ( // RQ9
         hit |-> {1'b0, idx} < n_eff)
         else $error("threshold beyond valid count took part");

      AST_FREQ_HIGH: assert property ( // RQ3
         en && is_freq && freq.upd && n_eff != 4'h0 &&
         freq.value >= thr_q[g][0] |=> auto_q[g] ##1 1'b1)
         else $error("frequency above first threshold not high");

      AST_TIME_CAM_END: assert property ( // RQ14
         en && is_cnt && !blocked[g] && !take && expired
         |=> auto_q[g] != $past(auto_q[g]))
         else $error("time cam did not end at expiry");
   end
endmodule
`default_nettype wire

// ===== cam_pkg.sv
package cam_pkg;
   localparam int NUM_TRACKS = 2;
   localparam int NUM_THR = 8;
   localparam int ADDR_W = 8;
   localparam int CTRL_W = 6;
   localparam int COUNT_W = 4;
   localparam int DUR_W = 15;
   // register map, one 128-byte window per track, track select in addr[7]
   localparam int TRACK_SEL_BIT = 7;
   localparam logic [6:0] OFF_CTRL = 7'h00;
   localparam logic [6:0] OFF_COUNT = 7'h04;
   localparam logic [6:0] OFF_LEVELS = 7'h08;
   localparam logic [6:0] OFF_STATUS = 7'h0c;
   localparam logic [1:0] BANK_THR = 2'h1;
   localparam logic [1:0] BANK_DUR = 2'h2;
   // control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_BLK_FWD_BIT = 1;
   localparam int CTRL_BLK_BWD_BIT = 2;
   localparam int CTRL_MANUAL_BIT = 3;
   localparam int CTRL_REF_LSB = 4;
   localparam logic [1:0] REF_COUNTER = 2'h0;
   localparam logic [1:0] REF_FREQ = 2'h2;
   // status fields
   localparam int STAT_PIN_BIT = 0;
   localparam int STAT_AUTO_BIT = 1;
   localparam int STAT_RUN_BIT = 2;
   localparam int STAT_FWD_BIT = 3;
   localparam int STAT_BLK_BIT = 4;
   // reset values and count limits
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam logic [COUNT_W-1:0] COUNT_RST = 4'h0;
   localparam logic [NUM_THR-1:0] LEVELS_RST = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_MAX = 4'h8;
   localparam logic [COUNT_W-1:0] COUNT_FREQ_MAX = 4'h2;
   // timing and bus response codes
   localparam int CLK_PERIOD_NS = 25;
   localparam int NS_PER_US = 1000;
   localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
   localparam logic [DUR_W-1:0] DUR_MAX_US = 15'd24000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } reg_wr_t;

   typedef struct packed {
      logic step;
      logic up;
      logic load;
      logic [31:0] value;
   } enc_in_t;

   typedef struct packed {
      logic upd;
      logic [31:0] value;
   } freq_in_t;
endpackage

// ===== axil_port.sv
`timescale 1ns/100ps
`default_nettype none
module axil_port (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [cam_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [cam_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output cam_pkg::reg_wr_t wr,
   input wire logic wr_err,
   output logic [cam_pkg::ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   import cam_pkg::*;

   logic aw_full_q;
   logic w_full_q;

   // address and data may arrive in either order; both park until paired
   assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
   assign s_axi_wready = !w_full_q && !s_axi_bvalid;
   assign wr_en = aw_full_q && w_full_q;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_addr = s_axi_araddr;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         wr <= '0;
      end else if (wr_en) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            wr.addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wr.data <= s_axi_wdata;
            wr.strb <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_err ? 32'h0000_0000 : rd_data;
         s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== dur_timer.sv
`timescale 1ns/100ps
`default_nettype none
module dur_timer #(
   parameter int CYC_PER_US = cam_pkg::CYC_PER_US
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic stop,
   input wire logic [cam_pkg::DUR_W-1:0] dur_us,
   output logic running,
   output logic expired
);
   import cam_pkg::*;

   localparam logic [7:0] PRE_TOP = 8'(CYC_PER_US - 1);

   logic [7:0] pre_q;
   logic [DUR_W-1:0] us_q;

   // start beats stop so a fresh cam restarts a timer still running
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         running <= 1'b0;
         expired <= 1'b0;
         pre_q <= 8'h00;
         us_q <= 15'h0000;
      end else begin
         expired <= 1'b0;
         if (start) begin
            running <= 1'b1;
            pre_q <= PRE_TOP;
            us_q <= dur_us;
         end else if (stop) begin
            running <= 1'b0;
         end else if (running) begin
            if (pre_q != 8'h00) begin
               pre_q <= pre_q - 8'h01;
            end else begin
               pre_q <= PRE_TOP;
               if (us_q == 15'h0001) begin
                  running <= 1'b0;
                  expired <= 1'b1;
               end
               us_q <= us_q - 15'h0001;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== cam_host.sv
`timescale 1ns/100ps
`default_nettype none
// fieldbus side: one write and one read at most in flight
module cam_host (
   input wire logic core_clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end

   // entered just after a rising edge; payload scrambled once taken
   // every call raises ready and none drops it, so it stays high after use
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid) begin
            done = 1'b1;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a);
      logic done;
      done = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) begin
            done = 1'b1;
         end
      end
   endtask
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import cam_pkg::*;
   logic core_clk, sys_rst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, dig_out_q;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   enc_in_t enc;
   freq_in_t freq;
   int err_count = 0;
   int n_tests = 0;
   logic [1:0] wr_q[$];
   logic [33:0] rd_q[$];
   logic [1:0] out_q[$];

   threshold_cam_output_switch dut_u (.core_clk, .sys_rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc,
      .freq, .dig_out_q);
   cam_host host_u (.core_clk, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic cmp(input logic [33:0] e, input logic [33:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp_b(input logic [1:0] e);
      cmp({32'h0000_0000, e}, {32'h0000_0000, s_axi_bresp});
   endtask
   task automatic cmp_r(input logic [33:0] e);
      cmp(e, {s_axi_rresp, s_axi_rdata});
   endtask
   task automatic cmp_out(input logic [1:0] e);
      cmp({32'h0000_0000, e}, {32'h0000_0000, dig_out_q});
   endtask

   // results are taken off the queues as they show at the ports
   always @(posedge core_clk) begin
      if (s_axi_bvalid && s_axi_bready && wr_q.size() > 0)
         cmp_b(wr_q.pop_front());
      if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0)
         cmp_r(rd_q.pop_front());
   end
   always @(negedge core_clk) begin
      if (out_q.size() > 0)
         cmp_out(out_q.pop_front());
   end

   task automatic w(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
      wr_q.push_back(r);
      host_u.wr(a, d);
   endtask
   task automatic r(input logic [7:0] a, input logic [33:0] e);
      rd_q.push_back(e);
      host_u.rd(a);
   endtask
   task automatic eo(input logic [1:0] e);
      out_q.push_back(e);
      @(posedge core_clk);
   endtask
   task automatic step(input logic u, input logic ld, input logic [31:0] v);
      enc.step <= !ld;
      enc.load <= ld;
      enc.up <= u;
      enc.value <= v;
      @(posedge core_clk);
      enc.step <= 1'b0;
      enc.load <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic fq(input logic [31:0] v);
      freq.upd <= 1'b1;
      freq.value <= v;
      @(posedge core_clk);
      freq.upd <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      test_done;
   end

   initial begin
      sys_rst = 1'b1;
      enc = '0;
      freq = '0;
      void'($urandom(70));
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      r(8'h00, {RESP_OKAY, 32'h0000_0000});
      r(8'h04, {RESP_OKAY, 32'h0000_0000});
      r(8'h08, {RESP_OKAY, 32'h0000_0000});
      r(8'h80, {RESP_OKAY, 32'h0000_0000});
      r(8'h10, {RESP_SLVERR, 32'h0000_0000});
      w(8'h10, 32'h0000_0001, RESP_SLVERR);
      w(8'h00, 32'h0000_0008);
      eo(2'b01);
      w(8'h20, 32'h0000_0064);
      w(8'h24, 32'h0000_006e);
      r(8'h20, {RESP_OKAY, 32'h0000_0064});
      w(8'h08, 32'h0000_0001);
      w(8'h04, 32'h0000_0002);
      w(8'h00, 32'h0000_0009);
      eo(2'b00);
      step(1'b1, 1'b0, 32'h0000_0063);
      eo(2'b00);
      step(1'b1, 1'b0, 32'h0000_0064);
      eo(2'b01);
      step(1'b1, 1'b1, 32'h0000_006e);
      eo(2'b01);
      step(1'b1, 1'b0, 32'h0000_006e);
      eo(2'b00);
      // values off every threshold must leave the level alone
      repeat (4) begin
         step(1'b1, 1'b0, $urandom_range(1000, 60000));
         eo(2'b00);
      end
      w(8'h04, 32'h0000_0001);
      step(1'b1, 1'b0, 32'h0000_0064);
      step(1'b1, 1'b0, 32'h0000_006e);
      eo(2'b01);
      w(8'h00, 32'h0000_000b);
      eo(2'b00);
      w(8'h00, 32'h0000_0005);
      step(1'b1, 1'b0, 32'h0000_0064);
      eo(2'b01);
      step(1'b0, 1'b0, 32'h0000_0063);
      eo(2'b00);
      w(8'h00, 32'h0000_0001);
      w(8'h04, 32'h0000_0002);
      step(1'b0, 1'b0, 32'h0000_006e);
      eo(2'b01);
      step(1'b0, 1'b0, 32'h0000_0064);
      eo(2'b00);
      w(8'h28, 32'h0000_012c);
      w(8'h2c, 32'h0000_0190);
      w(8'h48, 32'h0000_0002);
      w(8'h4c, 32'h0000_7530);
      r(8'h4c, {RESP_OKAY, 32'h0000_5dc0});
      w(8'h4c, 32'h0000_0002);
      w(8'h08, 32'h0000_000d);
      w(8'h04, 32'h0000_0004);
      step(1'b1, 1'b0, 32'h0000_012c);
      eo(2'b01);
      repeat (48) @(posedge core_clk);
      step(1'b1, 1'b0, 32'h0000_0190);
      repeat (40) @(posedge core_clk);
      eo(2'b01);
      repeat (60) @(posedge core_clk);
      eo(2'b00);
      w(8'ha0, 32'h0000_01f4);
      w(8'ha4, 32'h0000_00c8);
      w(8'h84, 32'h0000_0002);
      w(8'h80, 32'h0000_0021);
      fq(32'h0000_0258);
      eo(2'b10);
      fq($urandom_range(201, 499));
      eo(2'b10);
      fq(32'h0000_00c8);
      eo(2'b00);
      w(8'h84, 32'h0000_0001);
      fq(32'h0000_012c);
      eo(2'b00);
      fq(32'h0000_01f4);
      eo(2'b10);
      repeat (4) @(posedge core_clk);
      test_done;
   end
endmodule
`default_nettype wire
